/* logic/ltsq_code_decode.sv */
/*
 * Decodes the divider select code into polarity, the last count of the
 * programmable divider and the master-clock part of the start-up length.
 * Purely combinational; the code is assumed synchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ltsq_code_decode (
    input  wire logic [3:0]  code_i,
    output logic             pol_o,
    output logic [20:0]      ratio_last_o,
    output logic [9:0]       start_len_o
);

    logic [3:0] mirror;
    logic [4:0] shift;

    // Polarity from the code msb; ratio mirrored about the midpoint
    always_comb begin
        pol_o = code_i[ltsq_pkg::POL_BIT];
        mirror = pol_o ? (ltsq_pkg::CODE_MAX - code_i) : code_i;
        shift = 5'(mirror[2:0] * ltsq_pkg::RATIO_STEP_LOG2);
        ratio_last_o = (ltsq_pkg::RATIO_ONE << shift) - ltsq_pkg::RATIO_ONE;
        // Written as FIX + STEP*REF - STEP*code so codes above REF work
        start_len_o = ltsq_pkg::START_FIX
                    + 10'(ltsq_pkg::START_STEP * ltsq_pkg::START_REF)
                    - 10'(ltsq_pkg::START_STEP * {6'h00, code_i});
    end

endmodule // ltsq_code_decode

`default_nettype wire

/* logic/ltsq_pkg.sv */
/*
 * Shared constants for the long-period timer start-up sequencer: divider
 * select code layout, start-up interval figures, divider widths, states.
 * Assumes a 10 MHz system clock and a master-oscillator tick enable.
 */
package ltsq_pkg;

    // System clock period and the fixed analog part of start-up
    localparam int CLK_PERIOD_NS = 100;
    localparam int ANALOG_START_NS = 80000;
    // Least time, so round up to whole clock cycles
    localparam int ANALOG_START_CYC =
        (ANALOG_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Divider select code layout
    localparam int CODE_W = 4;
    localparam int POL_BIT = 3;
    localparam logic [3:0] CODE_MAX = 4'hf;

    // Start-up length in master periods: FIX + STEP * (REF - code)
    localparam int START_W = 10;
    localparam logic [9:0] START_FIX = 10'h100;
    localparam logic [9:0] START_STEP = 10'h010;
    localparam logic [9:0] START_REF = 10'h00c;
    localparam logic [9:0] ANALOG_LAST = 10'(ANALOG_START_CYC - 1);

    // Fixed prescale: half output period is 512 master periods per ratio
    localparam int PRE_W = 9;
    localparam logic [8:0] PRE_LAST = 9'h1ff;

    // Programmable ratio 8^k, k = 0..7, largest 2^21
    localparam int RATIO_W = 21;
    localparam int RATIO_STEP_LOG2 = 3;
    localparam logic [20:0] RATIO_ONE = 21'h000001;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_ANALOG = 2'b00,  // Fixed analog part of start-up
        ST_START  = 2'b01,  // Master-clock part of start-up
        ST_HELD   = 2'b10,  // Reset input asserted, output at polarity
        ST_RUN    = 2'b11   // Oscillating
    } ltsq_state_t;

endpackage : ltsq_pkg

/* logic/ltsq_tick_div.sv */
/*
 * Enabled modulo counter: emits a one-cycle tick on the enabled cycle that
 * reaches the last count. The last count may change at any time; a count
 * already past it also ticks, so a shortened ratio never waits a wrap.
 */
`timescale 1ns/100ps
`default_nettype none

module ltsq_tick_div #(
    parameter int W = 9
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          clr_i,
    input  wire logic          en_i,
    input  wire logic [W-1:0]  last_i,
    output logic               tick_o
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // Next count and terminal tick
    always_comb begin
        tick_o = en_i && !clr_i && (cnt_r >= last_i);
        if (clr_i) begin
            cnt_nxt = '0;
        end else if (tick_o) begin
            cnt_nxt = '0;
        end else if (en_i) begin
            cnt_nxt = cnt_r + W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Counter register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule // ltsq_tick_div

`default_nettype wire

/* logic/ltsq_timer.sv */
/*
 * Long-period timer core: power-up start-up interval, polarity handling,
 * reset input of build-selectable polarity, fixed and programmable
 * dividers and the square-wave output, including one-shot use.
 * Start-up has two parts: a fixed 80 us counted in system clocks, then
 * a code-dependent number of master ticks. The select code is trusted
 * only at the end of start-up; until then the output stays low.
 * After start-up the core is either held by the reset input, with the
 * output at the polarity level, or oscillating with a 50% duty cycle.
 * In one-shot use a high output blocks the master ticks, so the output
 * stays high until the reset input forces it to the polarity level or a power-on reset clears it.
 * Assumes: SYS_RST_I is the power-on reset and is raised again on any
 * supply bounce; MCLK_TICK_I is a one-cycle pulse per master oscillator
 * period and stays low while that oscillator is stopped; all inputs are
 * synchronous to CLK_I (10 MHz); codes above 12 shorten start-up, and
 * the select code may change at any time after start-up.
 */
// How it works
// - Output low from power-up until start-up ends
// - OUTPUT_POLARITY_BIT 0, reset idle: start oscillating from low
// - OUTPUT_POLARITY_BIT 0, reset held: output stays low
// - OUTPUT_POLARITY_BIT 1: low in start-up, then high
// - OUTPUT_POLARITY_BIT 1, reset held: output stays high
// - Reset release: polarity level for half period
// - Build parameter picks reset input active level
// - Polarity is the select code msb
// - Code sets both polarity and divide ratio
// - OUTPUT_POLARITY_BIT 0 POR: low start-up plus half period
// - Stopped master clock freezes the master-clock start-up count and the dividers
// - One-shot: high output stops the oscillator
// - Start-up: 256+16*(12-code) master periods plus 80us
// - Supply bounce restarts the start-up timer
// - Later reset release: only half period delay
// - Fixed divide by 512 ahead of ratio
// - Ratio 8^k, mirrored about code midpoint
// - Reset forces polarity level, clears dividers
`timescale 1ns/100ps
`default_nettype none

module ltsq_timer #(
    parameter bit RST_ACTIVE_HIGH = 1'b1   // Build variant of the reset pin
) (
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        MCLK_TICK_I,
    input  wire logic [3:0]  DIV_SEL_I,
    input  wire logic        TMR_RST_I,
    input  wire logic        ONE_SHOT_I,
    output logic             TMR_OUT_O,
    output logic             POL_O,
    output logic             START_DONE_O,
    output logic             RUNNING_O
);

    // Sequencer state and registered outputs
    ltsq_pkg::ltsq_state_t   state_r;
    ltsq_pkg::ltsq_state_t   state_nxt;
    logic [9:0]              start_cnt_r;
    logic [9:0]              start_cnt_nxt;
    logic                    out_r;
    logic                    out_nxt;
    logic                    pol_r;
    logic                    pol_nxt;
    logic                    done_r;
    logic                    done_nxt;
    logic                    run_r;
    logic                    run_nxt;

    // Decoded select code
    logic                    divider_select_pol;
    logic [20:0]             ratio_last;
    logic [9:0]              start_len;
    logic [9:0]              start_last;

    // Divider chain controls
    logic                    rst_active;
    logic                    mclk_run;
    logic                    div_clr;
    logic                    pre_tick;
    logic                    half_tick;

    // Phase events, decoded once and shared by the state groups
    logic                    analog_end;
    logic                    start_end;
    logic                    held_release;
    logic                    run_reset;
    logic                    run_toggle;

    // Select code decode
    ltsq_code_decode u_decode (
        .code_i       (DIV_SEL_I),
        .pol_o        (divider_select_pol),
        .ratio_last_o (ratio_last),
        .start_len_o  (start_len)
    );

    // Reset input level by build variant
    assign rst_active = RST_ACTIVE_HIGH ? TMR_RST_I : !TMR_RST_I;

    // Master tick gate: in one-shot use a high output halts the oscillator
    assign mclk_run = MCLK_TICK_I && !(ONE_SHOT_I && out_r);

    // Dividers count only while oscillating and are cleared otherwise
    assign div_clr = (state_r != ltsq_pkg::ST_RUN) || rst_active;

    // Last count of the master-clock part of start-up
    assign start_last = start_len - 10'h001;

    // Fixed prescale: one tick per 512 master periods into the ratio divider
    ltsq_tick_div #(
        .W (ltsq_pkg::PRE_W)
    ) u_prescale (
        .clk_i  (CLK_I),
        .rst_i  (SYS_RST_I),
        .clr_i  (div_clr),
        .en_i   (mclk_run),
        .last_i (ltsq_pkg::PRE_LAST),
        .tick_o (pre_tick)
    );

    // Programmable divider over the prescaled ticks
    ltsq_tick_div #(
        .W (ltsq_pkg::RATIO_W)
    ) u_ratio (
        .clk_i  (CLK_I),
        .rst_i  (SYS_RST_I),
        .clr_i  (div_clr),
        .en_i   (pre_tick),
        .last_i (ratio_last),
        .tick_o (half_tick)
    );

    // Fixed analog part ends on its last system clock
    assign analog_end = (state_r == ltsq_pkg::ST_ANALOG)
                     && (start_cnt_r >= ltsq_pkg::ANALOG_LAST);

    // Master-clock part ends on the tick that completes its length
    assign start_end = (state_r == ltsq_pkg::ST_START) && mclk_run
                    && (start_cnt_r >= start_last);

    // Reset input dropped while held: the oscillator may start
    assign held_release = (state_r == ltsq_pkg::ST_HELD)
                       && !rst_active;

    // Reset input raised while oscillating wins over a half tick
    assign run_reset = (state_r == ltsq_pkg::ST_RUN) && rst_active;

    // Half period complete while oscillating and not reset
    assign run_toggle = (state_r == ltsq_pkg::ST_RUN) && !rst_active
                     && half_tick;

    // Start-up counter: system clocks, then master ticks
    always_comb begin
        start_cnt_nxt = start_cnt_r;
        unique case (state_r)
            // Fixed analog part counts every system clock
            ltsq_pkg::ST_ANALOG: begin
                if (analog_end) begin
                    start_cnt_nxt = '0;
                end else begin
                    start_cnt_nxt = start_cnt_r + 10'h001;
                end
            end
            // Master-clock part counts only live master ticks
            ltsq_pkg::ST_START: begin
                if (start_end) begin
                    start_cnt_nxt = '0;
                end else if (mclk_run) begin
                    start_cnt_nxt = start_cnt_r + 10'h001;
                end
            end
            // Idle once start-up is over
            ltsq_pkg::ST_HELD,
            ltsq_pkg::ST_RUN: begin
                start_cnt_nxt = start_cnt_r;
            end
        endcase
    end

    // Start-up counter register; a supply bounce restarts it
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            start_cnt_r <= '0;
        end else begin
            start_cnt_r <= start_cnt_nxt;
        end
    end

    // Phase sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // Fixed analog part first, then the master-clock part
            ltsq_pkg::ST_ANALOG: begin
                if (analog_end) begin
                    state_nxt = ltsq_pkg::ST_START;
                end
            end
            // Reset input is looked at only where start-up ends
            ltsq_pkg::ST_START: begin
                if (start_end && rst_active) begin
                    state_nxt = ltsq_pkg::ST_HELD;
                end else if (start_end) begin
                    state_nxt = ltsq_pkg::ST_RUN;
                end
            end
            // Release starts the oscillator, no start-up added
            ltsq_pkg::ST_HELD: begin
                if (held_release) begin
                    state_nxt = ltsq_pkg::ST_RUN;
                end
            end
            // Reset input stops the oscillator again
            ltsq_pkg::ST_RUN: begin
                if (run_reset) begin
                    state_nxt = ltsq_pkg::ST_HELD;
                end
            end
        endcase
    end

    // Phase register; power-on reset restarts start-up from scratch
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_r <= ltsq_pkg::ST_ANALOG;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Output level and polarity in use
    always_comb begin
        out_nxt = out_r;
        pol_nxt = pol_r;
        unique case (state_r)
            // Output low all through the analog part
            ltsq_pkg::ST_ANALOG: begin
                out_nxt = 1'b0;
            end
            // Code only trusted at the end of start-up
            ltsq_pkg::ST_START: begin
                out_nxt = 1'b0;
                if (start_end) begin
                    pol_nxt = divider_select_pol;
                    out_nxt = divider_select_pol;
                end
            end
            // Reset held: output pinned at the polarity level
            ltsq_pkg::ST_HELD: begin
                pol_nxt = divider_select_pol;
                out_nxt = divider_select_pol;
            end
            // Oscillating: one toggle per half period
            ltsq_pkg::ST_RUN: begin
                pol_nxt = divider_select_pol;
                if (run_reset) begin
                    out_nxt = divider_select_pol;
                end else if (run_toggle) begin
                    out_nxt = !out_r;
                end
            end
        endcase
    end

    // Output and polarity registers; both low from power-up
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            out_r <= 1'b0;
            pol_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            pol_r <= pol_nxt;
        end
    end

    // Status flags: start-up finished and oscillator running
    always_comb begin
        done_nxt = done_r;
        run_nxt = run_r;
        if (start_end) begin
            done_nxt = 1'b1;
        end
        if (start_end || held_release) begin
            run_nxt = !rst_active;
        end else if (run_reset) begin
            run_nxt = 1'b0;
        end
    end

    // Status flag registers
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            done_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
            run_r <= run_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign TMR_OUT_O = out_r;
    assign POL_O = pol_r;
    assign START_DONE_O = done_r;
    assign RUNNING_O = run_r;

endmodule // ltsq_timer

`default_nettype wire

/* verification/ltsq_timer_chk.sv */
/* Port checker for the long-period timer core.
   Assumes it is bound to every ltsq_timer instance. */
`timescale 1ns/100ps
`default_nettype none

module ltsq_timer_chk #(
    parameter bit RST_ACTIVE_HIGH = 1'b1
) (
    input wire logic       CLK_I,
    input wire logic       SYS_RST_I,
    input wire logic       MCLK_TICK_I,
    input wire logic [3:0] DIV_SEL_I,
    input wire logic       TMR_RST_I,
    input wire logic       ONE_SHOT_I,
    input wire logic       TMR_OUT_O,
    input wire logic       POL_O,
    input wire logic       START_DONE_O,
    input wire logic       RUNNING_O
);
    logic        rst_act;
    logic [10:0] cyc_r;
    logic [10:0] cyc_nxt;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // Reset input level as this build reads it
    assign rst_act = RST_ACTIVE_HIGH ? TMR_RST_I : !TMR_RST_I;

    // Clocks since power-on, saturating
    always_comb cyc_nxt = (cyc_r == 11'h7ff) ? cyc_r : cyc_r + 11'h001;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) cyc_r <= 11'h000;
        else cyc_r <= cyc_nxt;
    end

    property p_low_startup;
        !START_DONE_O |-> !TMR_OUT_O && !POL_O;
    endproperty
    a_low_startup: assert property (p_low_startup)
        else $error("output not low during start-up");
    property p_start_out;
        $rose(START_DONE_O) |-> TMR_OUT_O == POL_O;
    endproperty
    a_start_out: assert property (p_start_out)
        else $error("output not at polarity at end of start-up");
    property p_pol_msb;
        START_DONE_O && $stable(DIV_SEL_I) |-> POL_O == DIV_SEL_I[3];
    endproperty
    a_pol_msb: assert property (p_pol_msb)
        else $error("polarity differs from code msb");
    property p_held;
        START_DONE_O && rst_act && $stable(DIV_SEL_I)
            |=> !RUNNING_O && TMR_OUT_O == POL_O;
    endproperty
    a_held: assert property (p_held)
        else $error("reset does not force the polarity level");
    property p_release;
        START_DONE_O && !rst_act && !RUNNING_O |=> RUNNING_O;
    endproperty
    a_release: assert property (p_release)
        else $error("oscillator not started on reset release");
    property p_tick_only;
        $past(RUNNING_O) && !$past(MCLK_TICK_I) && !$past(rst_act)
            && RUNNING_O |-> $stable(TMR_OUT_O);
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("output moved without a master tick");
    property p_one_shot;
        ONE_SHOT_I && TMR_OUT_O && RUNNING_O && !rst_act |=> TMR_OUT_O;
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("one-shot output left the high level");
    property p_start_len;
        $rose(START_DONE_O) |-> cyc_r >= 11'h3e8;
    endproperty
    a_start_len: assert property (p_start_len)
        else $error("start-up interval too short");
endmodule // ltsq_timer_chk

bind ltsq_timer ltsq_timer_chk #(.RST_ACTIVE_HIGH(RST_ACTIVE_HIGH)) i_chk (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .MCLK_TICK_I(MCLK_TICK_I),
    .DIV_SEL_I(DIV_SEL_I), .TMR_RST_I(TMR_RST_I), .ONE_SHOT_I(ONE_SHOT_I),
    .TMR_OUT_O(TMR_OUT_O), .POL_O(POL_O), .START_DONE_O(START_DONE_O),
    .RUNNING_O(RUNNING_O));

`default_nettype wire

/* verification/tb.sv */
/* Self-checking bench for the timer core, both reset builds side by side.
   Assumes the port checker is bound to every core instance. */
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       tick = 1'b0;
    logic       trst = 1'b0;
    logic       one = 1'b0;
    logic [3:0] code = 4'h0;
    wire  [3:0] hi_o;       // Out, pol, done, run of active-high build
    wire  [3:0] lo_o;       // Same for the active-low build
    int         failures = 0;
    int         checks = 0;

    // 10 MHz clock
    initial forever #50 clk = ~clk;

    // Two builds fed the same stimulus, reset input inverted for one
    ltsq_timer #(.RST_ACTIVE_HIGH(1'b1)) i_dut (
        .CLK_I(clk), .SYS_RST_I(sys_rst), .MCLK_TICK_I(tick),
        .DIV_SEL_I(code), .TMR_RST_I(trst), .ONE_SHOT_I(one),
        .TMR_OUT_O(hi_o[3]), .POL_O(hi_o[2]), .START_DONE_O(hi_o[1]),
        .RUNNING_O(hi_o[0]));
    ltsq_timer #(.RST_ACTIVE_HIGH(1'b0)) i_dut_lo (
        .CLK_I(clk), .SYS_RST_I(sys_rst), .MCLK_TICK_I(tick),
        .DIV_SEL_I(code), .TMR_RST_I(!trst), .ONE_SHOT_I(one),
        .TMR_OUT_O(lo_o[3]), .POL_O(lo_o[2]), .START_DONE_O(lo_o[1]),
        .RUNNING_O(lo_o[0]));

    // Expected counts in master ticks
    function automatic int half_ticks(logic [3:0] c);
        return 512 << (3 * (c[3] ? 15 - int'(c) : int'(c)));
    endfunction
    function automatic int start_ticks(logic [3:0] c);
        return 256 + 16 * (12 - int'(c));
    endfunction

    task automatic check(string nm, logic [3:0] e, logic [3:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Compare both builds at mid-cycle
    task automatic look(logic [3:0] e);
        @(negedge clk);
        check("outputs", e, hi_o);
        check("low build", e, lo_o);
    endtask
    // Ticks with random gaps; the last one is sampled before return
    task automatic ticks(int n);
        repeat (n) begin
            @(posedge clk) tick <= 1'b1;
            repeat ($urandom % 3) @(posedge clk) tick <= 1'b0;
        end
        @(posedge clk) tick <= 1'b0;
    endtask
    task automatic por(logic [3:0] c, logic r);
        @(posedge clk);
        sys_rst <= 1'b1;
        code <= c;
        trst <= r;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (810) @(posedge clk);
        look(4'h0);
    endtask
    task automatic start(logic [3:0] e);
        ticks(start_ticks(code) - 1);
        look(4'h0);
        ticks(1);
        look(e);
    endtask
    task automatic half(logic [3:0] b, logic [3:0] a);
        ticks(half_ticks(code) - 1);
        look(b);
        ticks(1);
        look(a);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        wrap_up();
    end

    // Main sequence
    initial begin
        void'($urandom(17719));
        por(4'h0, 1'b0);
        start(4'b0011);
        half(4'b0011, 4'b1011);
        half(4'b1011, 4'b0011);
        // Held at end of start-up, with a supply bounce midway
        por(4'hf, 1'b1);
        ticks(100);
        por(4'hf, 1'b1);
        start(4'b1110);
        ticks(50);
        look(4'b1110);
        // Every code while held
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) code <= 4'(i);
            ticks(1);
            look({i[3], i[3], 2'b10});
        end
        // Release, first half period, then one-shot
        @(posedge clk) code <= 4'h1;
        @(posedge clk) trst <= 1'b0;
        ticks(0);
        look(4'b0011);
        half(4'b0011, 4'b1011);
        @(posedge clk) one <= 1'b1;
        ticks(4200);
        look(4'b1011);
        // Mirrored code gives the same ratio, opposite polarity
        @(posedge clk) trst <= 1'b1;
        code <= 4'he;
        ticks(0);
        look(4'b1110);
        @(posedge clk) one <= 1'b0;
        trst <= 1'b0;
        ticks(0);
        look(4'b1111);
        half(4'b1111, 4'b0111);
        wrap_up();
    end
endmodule // tb

`default_nettype wire
